// file: core/dfi_pkg.sv
// Shared constants for the controller and PHY ends of the DFI link
package dfi_pkg;
   // Command kinds offered by the controller's user port
   localparam logic [1:0] KIND_OTHER = 2'h0;
   localparam logic [1:0] KIND_READ = 2'h1;
   localparam logic [1:0] KIND_WRITE = 2'h2;
   // Reset and idle levels of the control outputs
   localparam logic STROBE_IDLE = 1'h1;
   localparam logic CKE_RESET = 1'h0;
   localparam logic ODT_RESET = 1'h0;
   // Field widths
   localparam int LEN_W = 4;
   localparam int WAKE_W = 4;
   localparam int UPD_TYPE_W = 2;
   // PHY-end cycle counts
   localparam int PHY_INIT_CYC = 8;
   localparam int PHY_REINIT_CYC = 6;
   localparam int PHY_UPD_CYC0 = 4;
   localparam int PHY_UPD_CYC1 = 8;
   localparam int PHY_UPD_CYC2 = 16;
   localparam int PHY_UPD_CYC3 = 32;
   localparam int PHY_RD_DELAY = 3;
   localparam int PHY_WR_DELAY = 2;
endpackage

// file: core/dfi_if.sv
// DFI signal bundle joining the controller end and the PHY end
`timescale 1ns/1ps
`default_nettype none
interface dfi_if #(
   parameter int DW = 32,
   parameter int EW = 8,
   parameter int SLICES = 4,
   parameter int AW = 16,
   parameter int BW = 3,
   parameter int CSW = 1,
   parameter int CAW = 10
);
   localparam int MW = (DW + 7) / 8;
   localparam int EMW = (EW + 7) / 8;
   logic dfi_init_start;
   logic dfi_init_complete;
   logic dfi_rddata_en;
   logic dfi_rdecc_en;
   logic dfi_rddata_valid;
   logic [DW-1:0] dfi_rddata;
   logic [EW-1:0] dfi_rdecc;
   logic dfi_ras_n;
   logic dfi_cas_n;
   logic dfi_we_n;
   logic [CSW-1:0] dfi_cke;
   logic [CSW-1:0] dfi_cs_n;
   logic [CSW-1:0] dfi_odt;
   logic [CAW-1:0] dfi_cmd_addr;
   logic [AW-1:0] dfi_address;
   logic [BW-1:0] dfi_bank;
   logic [SLICES-1:0] dfi_wrdata_en;
   logic [DW-1:0] dfi_wrdata;
   logic [MW-1:0] dfi_wrdata_mask;
   logic [SLICES-1:0] dfi_wrecc_en;
   logic [EW-1:0] dfi_wrecc;
   logic [EMW-1:0] dfi_wrecc_mask;
   logic dfi_dram_clk_disable;
   logic dfi_phyupd_req;
   logic dfi_phyupd_ack;
   logic [1:0] dfi_phyupd_type;
   logic dfi_clp_req;
   logic dfi_clp_ack;
   logic [3:0] dfi_clp_wakeup;
   logic dfi_rdlp_req;
   logic dfi_rdlp_ack;
   logic [3:0] dfi_rdlp_wakeup;

   modport mc (
      output dfi_init_start, dfi_rddata_en, dfi_rdecc_en, dfi_ras_n, dfi_cas_n, dfi_we_n, dfi_cke,
      output dfi_cs_n, dfi_odt, dfi_cmd_addr, dfi_address, dfi_bank, dfi_wrdata_en, dfi_wrdata,
      output dfi_wrdata_mask, dfi_wrecc_en, dfi_wrecc, dfi_wrecc_mask, dfi_dram_clk_disable,
      output dfi_phyupd_ack, dfi_clp_req, dfi_clp_wakeup, dfi_rdlp_req, dfi_rdlp_wakeup,
      input dfi_init_complete, dfi_rddata_valid, dfi_rddata, dfi_rdecc, dfi_phyupd_req,
      input dfi_phyupd_type, dfi_clp_ack, dfi_rdlp_ack
   );
   modport phy (
      input dfi_init_start, dfi_rddata_en, dfi_rdecc_en, dfi_ras_n, dfi_cas_n, dfi_we_n, dfi_cke,
      input dfi_cs_n, dfi_odt, dfi_cmd_addr, dfi_address, dfi_bank, dfi_wrdata_en, dfi_wrdata,
      input dfi_wrdata_mask, dfi_wrecc_en, dfi_wrecc, dfi_wrecc_mask, dfi_dram_clk_disable,
      input dfi_phyupd_ack, dfi_clp_req, dfi_clp_wakeup, dfi_rdlp_req, dfi_rdlp_wakeup,
      output dfi_init_complete, dfi_rddata_valid, dfi_rddata, dfi_rdecc, dfi_phyupd_req,
      output dfi_phyupd_type, dfi_clp_ack, dfi_rdlp_ack
   );
endinterface
`default_nettype wire

// file: core/dfi_phy_end.sv
// PHY end of the DFI link: init, read return, write capture, update and low-power answers
`timescale 1ns/1ps
`default_nettype none
module dfi_phy_end #(
   parameter int DW = 32,
   parameter int EW = 8,
   parameter int SLICES = 4,
   parameter int AW = 16,
   parameter int BW = 3,
   parameter int CSW = 1,
   parameter int CAW = 10,
   parameter int RD_DELAY = dfi_pkg::PHY_RD_DELAY,
   parameter int WR_DELAY = dfi_pkg::PHY_WR_DELAY
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // DFI link
   dfi_if.phy dfi,
   // Captured command
   output logic cmd_seen,
   output logic [AW-1:0] cmd_address,
   output logic [BW-1:0] cmd_bank,
   // Captured write beats
   output logic wr_beat_valid,
   output logic [DW-1:0] wr_beat_data,
   output logic [(DW+7)/8-1:0] wr_beat_mask,
   output logic [EW-1:0] wr_beat_ecc,
   // Read data source
   output logic rd_pop,
   input wire logic [DW-1:0] rd_src_data,
   input wire logic [EW-1:0] rd_src_ecc,
   // Update and low-power policy
   input wire logic upd_go,
   input wire logic [1:0] upd_type,
   output logic upd_busy,
   input wire logic lp_ack_en,
   // Memory clock state
   output logic mem_clk_run
);
   typedef enum logic [1:0] {DFIP_RST = 2'h0, DFIP_READY = 2'h1, DFIP_ACKD = 2'h3, DFIP_REINIT = 2'h2} dfip_init_e;
   typedef enum logic [1:0] {DFIP_U_IDLE = 2'h0, DFIP_U_REQ = 2'h1, DFIP_U_RUN = 2'h3} dfip_upd_e;

   dfip_init_e ist_q;
   dfip_upd_e ust_q;
   logic [7:0] icnt_q;
   logic [7:0] ucnt_q;
   logic [7:0] ulen_q;
   logic [1:0] utype_q;
   logic [RD_DELAY-1:0] rd_sr_q;
   logic [WR_DELAY-1:0] wr_sr_q;
   logic rvalid_q;
   logic [DW-1:0] rdata_q;
   logic [EW-1:0] recc_q;
   logic clp_ack_q;
   logic rdlp_ack_q;
   logic [7:0] upd_len;
   logic wr_tap;

   assign wr_tap = wr_sr_q[WR_DELAY-1];
   assign rd_pop = rd_sr_q[RD_DELAY-1];
   assign upd_len = (upd_type == 2'h0) ? 8'(dfi_pkg::PHY_UPD_CYC0) :
                    (upd_type == 2'h1) ? 8'(dfi_pkg::PHY_UPD_CYC1) :
                    (upd_type == 2'h2) ? 8'(dfi_pkg::PHY_UPD_CYC2) : 8'(dfi_pkg::PHY_UPD_CYC3);
   assign upd_busy = (ust_q != DFIP_U_IDLE);

   // Init complete drops as the acknowledge of init start, rises after re-init
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ist_q <= DFIP_RST;
         icnt_q <= 8'h00;
      end
      else
      begin
         case (ist_q)
            DFIP_RST:
            begin
               icnt_q <= icnt_q + 8'h01;
               if (icnt_q == 8'(dfi_pkg::PHY_INIT_CYC))
                  ist_q <= DFIP_READY;
            end
            DFIP_READY:
               if (dfi.dfi_init_start)
                  ist_q <= DFIP_ACKD;
            DFIP_ACKD:
            begin
               icnt_q <= 8'h00;
               if (!dfi.dfi_init_start)
                  ist_q <= DFIP_REINIT;
            end
            DFIP_REINIT:
            begin
               icnt_q <= icnt_q + 8'h01;
               if (icnt_q == 8'(dfi_pkg::PHY_REINIT_CYC))
                  ist_q <= DFIP_READY;
            end
            default: ist_q <= DFIP_RST;
         endcase
      end
   end
   assign dfi.dfi_init_complete = (ist_q == DFIP_READY);

   // Update request held through acknowledge and the whole update
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ust_q <= DFIP_U_IDLE;
         ucnt_q <= 8'h00;
         ulen_q <= 8'h00;
         utype_q <= 2'h0;
      end
      else
      begin
         case (ust_q)
            DFIP_U_IDLE:
               if (upd_go && ist_q == DFIP_READY)
               begin
                  ust_q <= DFIP_U_REQ;
                  utype_q <= upd_type;
                  ulen_q <= upd_len;
                  ucnt_q <= 8'h00;
               end
            DFIP_U_REQ:
               if (dfi.dfi_phyupd_ack)
                  ust_q <= DFIP_U_RUN;
            DFIP_U_RUN:
            begin
               ucnt_q <= ucnt_q + 8'h01;
               if (ucnt_q == ulen_q)
                  ust_q <= DFIP_U_IDLE;
            end
            default: ust_q <= DFIP_U_IDLE;
         endcase
      end
   end
   assign dfi.dfi_phyupd_req = (ust_q != DFIP_U_IDLE);
   assign dfi.dfi_phyupd_type = utype_q;

   // Read return and write capture delay lines
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rd_sr_q <= '0;
         wr_sr_q <= '0;
         rvalid_q <= 1'h0;
         rdata_q <= '0;
         recc_q <= '0;
         wr_beat_valid <= 1'h0;
         wr_beat_data <= '0;
         wr_beat_mask <= '0;
         wr_beat_ecc <= '0;
      end
      else
      begin
         rd_sr_q <= RD_DELAY'({rd_sr_q, dfi.dfi_rddata_en});
         wr_sr_q <= WR_DELAY'({wr_sr_q, dfi.dfi_wrdata_en[0]});
         rvalid_q <= rd_pop;
         if (rd_pop)
         begin
            rdata_q <= rd_src_data;
            recc_q <= rd_src_ecc;
         end
         wr_beat_valid <= wr_tap;
         if (wr_tap)
         begin
            wr_beat_data <= dfi.dfi_wrdata;
            wr_beat_mask <= dfi.dfi_wrdata_mask;
            wr_beat_ecc <= dfi.dfi_wrecc;
         end
      end
   end
   assign dfi.dfi_rddata_valid = rvalid_q;
   assign dfi.dfi_rddata = rdata_q;
   assign dfi.dfi_rdecc = recc_q;

   // Command capture, low-power answers and memory clock gate
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cmd_seen <= 1'h0;
         cmd_address <= '0;
         cmd_bank <= '0;
         clp_ack_q <= 1'h0;
         rdlp_ack_q <= 1'h0;
         mem_clk_run <= 1'h0;
      end
      else
      begin
         cmd_seen <= ~&dfi.dfi_cs_n;
         if (~&dfi.dfi_cs_n)
         begin
            cmd_address <= dfi.dfi_address;
            cmd_bank <= dfi.dfi_bank;
         end
         clp_ack_q <= dfi.dfi_clp_req & lp_ack_en;
         rdlp_ack_q <= dfi.dfi_rdlp_req & lp_ack_en;
         mem_clk_run <= ~dfi.dfi_dram_clk_disable & (ist_q == DFIP_READY);
      end
   end
   assign dfi.dfi_clp_ack = clp_ack_q;
   assign dfi.dfi_rdlp_ack = rdlp_ack_q;
endmodule
`default_nettype wire

// file: core/dfi_mc_end.sv
// Controller end of the DFI link: command issue, read/write enables, update and low-power
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Outputs stay default until PHY init completes; dfi_clp_wakeup and dfi_rdlp_wakeup follow their inputs throughout
// - PHY drops init complete to acknowledge re-init
// - PHY re-raises init complete within tinit_complete
// - PHY read valid spans exactly the data words
// - PHY returns read data within tphy_rdlat
// - Read enable trddata_en after read, spans data
// - Read ECC follows read data and enable timing
// - Every command drives strobes, address, bank, termination
// - Write data starts tphy_wrdata after enable, matches span
// - One mask bit per byte, partial top byte
// - Write enable tphy_wrlat after command, held contiguous
// - One write enable bit per data slice
// - Write ECC, mask, valid share write timing
// - Clock disable holds memory clock constant
// - PHY holds update request until update done
// - Always acknowledge update; hold until request drops
// - No traffic while update acknowledge is high
// - PHY supplies a four-way update type
// - Separate command and read low-power requests, wakeup
// - Low-power acknowledge is optional; never waited for
// - Write data lead is configurable
module dfi_mc_end #(
   parameter int DW = 32,
   parameter int EW = 8,
   parameter int SLICES = 4,
   parameter int AW = 16,
   parameter int BW = 3,
   parameter int CSW = 1,
   parameter int CAW = 10,
   parameter int T_W = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // DFI link
   dfi_if.mc dfi,
   // Command request
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [1:0] cmd_kind,
   input wire logic [dfi_pkg::LEN_W-1:0] cmd_len,
   input wire logic cmd_ras_n,
   input wire logic cmd_cas_n,
   input wire logic cmd_we_n,
   input wire logic [CSW-1:0] cmd_cs_n,
   input wire logic [AW-1:0] cmd_addr,
   input wire logic [BW-1:0] cmd_bank,
   input wire logic [CAW-1:0] cmd_ca,
   input wire logic [CSW-1:0] cke_level,
   input wire logic [CSW-1:0] odt_level,
   // Write data pull
   output logic wr_pull,
   input wire logic [DW-1:0] wr_data,
   input wire logic [(DW+7)/8-1:0] wr_mask,
   input wire logic [EW-1:0] wr_ecc,
   input wire logic [(EW+7)/8-1:0] wr_ecc_mask,
   // Read data out
   output logic rd_valid,
   output logic [DW-1:0] rd_data,
   output logic [EW-1:0] rd_ecc,
   // Static timing configuration
   input wire logic [T_W-1:0] cfg_wrlat,
   input wire logic [T_W-1:0] cfg_wrdata,
   input wire logic [T_W-1:0] cfg_rddata_en,
   input wire logic [T_W-1:0] cfg_rdlat,
   input wire logic [T_W-1:0] cfg_init_cmp,
   // Frequency change, clock and low-power control
   input wire logic freq_req,
   output logic freq_done,
   output logic init_timeout,
   input wire logic clk_disable_req,
   input wire logic lp_cmd_req,
   input wire logic [dfi_pkg::WAKE_W-1:0] lp_cmd_wakeup,
   input wire logic lp_rd_req,
   input wire logic [dfi_pkg::WAKE_W-1:0] lp_rd_wakeup,
   output logic lp_cmd_acked,
   output logic lp_rd_acked,
   output logic upd_active
);
   localparam int CW = T_W + 2;
   typedef enum logic [2:0] {DFIM_INIT = 3'h0, DFIM_IDLE = 3'h1, DFIM_RUN = 3'h3, DFIM_UPD = 3'h2,
                             DFIM_FRQ_REQ = 3'h6, DFIM_FRQ_WAIT = 3'h7} dfim_state_e;

   dfim_state_e st_q;
   logic [CW-1:0] t_q;
   logic [CW-1:0] end_q;
   logic [CW-1:0] len_q;
   logic is_wr_q;
   logic is_rd_q;
   logic [T_W-1:0] wrlat_q;
   logic [T_W-1:0] wrdata_q;
   logic [T_W-1:0] rden_q;
   logic [T_W-1:0] rdlat_q;
   logic [T_W-1:0] initc_q;
   logic ras_n_q;
   logic cas_n_q;
   logic we_n_q;
   logic [CSW-1:0] cs_n_q;
   logic [AW-1:0] addr_q;
   logic [BW-1:0] bank_q;
   logic [CAW-1:0] ca_q;
   logic wen_q;
   logic ren_q;
   logic [DW-1:0] wdata_q;
   logic [(DW+7)/8-1:0] wmask_q;
   logic [EW-1:0] wecc_q;
   logic [(EW+7)/8-1:0] wecc_mask_q;
   logic init_start_q;
   logic upd_ack_q;
   logic misc_ok_q;

   wire init_ok = dfi.dfi_init_complete;
   wire idle = (st_q == DFIM_IDLE);
   wire issue = cmd_valid & cmd_ready;
   wire [CW-1:0] t_d = t_q + CW'(1);
   wire [CW-1:0] wen_lo = CW'(wrlat_q);
   wire [CW-1:0] wd_lo = CW'(wrlat_q) + CW'(wrdata_q);
   wire [CW-1:0] ren_lo = CW'(rden_q);
   wire [CW-1:0] new_len = CW'(cmd_len);
   wire [CW-1:0] new_wr_end = CW'(cfg_wrlat) + CW'(cfg_wrdata) + new_len;
   wire [CW-1:0] new_rd_end = CW'(cfg_rddata_en) + CW'(cfg_rdlat) + new_len;
   wire run = (st_q == DFIM_RUN);
   wire wen_d = run & is_wr_q & (t_d >= wen_lo) & (t_d < wen_lo + len_q);
   wire wd_d = run & is_wr_q & (t_d >= wd_lo) & (t_d < wd_lo + len_q);
   wire ren_d = run & is_rd_q & (t_d >= ren_lo) & (t_d < ren_lo + len_q);

   // Commands only when initialised, idle and no update or re-init pending
   assign cmd_ready = idle & init_ok & ~dfi.dfi_phyupd_req & ~freq_req;
   assign wr_pull = wd_d;
   assign upd_active = upd_ack_q;

   // Sequencer, timing sampling, update and frequency-change handshakes
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_q <= DFIM_INIT;
         t_q <= '0;
         end_q <= '0;
         len_q <= '0;
         is_wr_q <= 1'h0;
         is_rd_q <= 1'h0;
         wrlat_q <= '0;
         wrdata_q <= '0;
         rden_q <= '0;
         rdlat_q <= '0;
         initc_q <= '0;
         init_start_q <= 1'h0;
         upd_ack_q <= 1'h0;
         freq_done <= 1'h0;
         init_timeout <= 1'h0;
      end
      else
      begin
         freq_done <= 1'h0;
         t_q <= t_d;
         case (st_q)
            DFIM_INIT:
               if (init_ok)
                  st_q <= DFIM_IDLE;
            DFIM_IDLE:
            begin
               // Sampled only here so a change never bends a transfer in flight
               wrlat_q <= cfg_wrlat;
               wrdata_q <= cfg_wrdata;
               rden_q <= cfg_rddata_en;
               rdlat_q <= cfg_rdlat;
               initc_q <= cfg_init_cmp;
               t_q <= '0;
               if (dfi.dfi_phyupd_req)
               begin
                  st_q <= DFIM_UPD;
                  upd_ack_q <= 1'h1;
               end
               else if (freq_req && init_ok)
               begin
                  st_q <= DFIM_FRQ_REQ;
                  init_start_q <= 1'h1;
                  init_timeout <= 1'h0;
               end
               else if (issue)
               begin
                  st_q <= DFIM_RUN;
                  len_q <= new_len;
                  is_wr_q <= (cmd_kind == dfi_pkg::KIND_WRITE);
                  is_rd_q <= (cmd_kind == dfi_pkg::KIND_READ);
                  if (cmd_kind == dfi_pkg::KIND_WRITE)
                     end_q <= new_wr_end;
                  else if (cmd_kind == dfi_pkg::KIND_READ)
                     end_q <= new_rd_end;
                  else
                     end_q <= '0;
               end
            end
            DFIM_RUN:
               if (t_q >= end_q)
                  st_q <= DFIM_IDLE;
            DFIM_UPD:
               if (!dfi.dfi_phyupd_req)
               begin
                  st_q <= DFIM_IDLE;
                  upd_ack_q <= 1'h0;
               end
            DFIM_FRQ_REQ:
            begin
               t_q <= '0;
               if (!init_ok)
               begin
                  st_q <= DFIM_FRQ_WAIT;
                  init_start_q <= 1'h0;
               end
            end
            DFIM_FRQ_WAIT:
               if (init_ok)
               begin
                  st_q <= DFIM_IDLE;
                  freq_done <= 1'h1;
               end
               else if (t_q >= CW'(initc_q))
                  init_timeout <= 1'h1;
            default: st_q <= DFIM_INIT;
         endcase
      end
   end

   // Command bus: one cycle per command, no-operation levels otherwise
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ras_n_q <= dfi_pkg::STROBE_IDLE;
         cas_n_q <= dfi_pkg::STROBE_IDLE;
         we_n_q <= dfi_pkg::STROBE_IDLE;
         cs_n_q <= {CSW{dfi_pkg::STROBE_IDLE}};
         addr_q <= '0;
         bank_q <= '0;
         ca_q <= '0;
      end
      else
      begin
         ras_n_q <= issue ? cmd_ras_n : dfi_pkg::STROBE_IDLE;
         cas_n_q <= issue ? cmd_cas_n : dfi_pkg::STROBE_IDLE;
         we_n_q <= issue ? cmd_we_n : dfi_pkg::STROBE_IDLE;
         cs_n_q <= issue ? cmd_cs_n : {CSW{dfi_pkg::STROBE_IDLE}};
         if (issue)
         begin
            addr_q <= cmd_addr;
            bank_q <= cmd_bank;
            ca_q <= cmd_ca;
         end
      end
   end

   // Data enables and write data stream
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wen_q <= 1'h0;
         ren_q <= 1'h0;
         wdata_q <= '0;
         wmask_q <= '0;
         wecc_q <= '0;
         wecc_mask_q <= '0;
         rd_valid <= 1'h0;
         rd_data <= '0;
         rd_ecc <= '0;
         misc_ok_q <= 1'h0;
      end
      else
      begin
         wen_q <= wen_d;
         ren_q <= ren_d;
         if (wd_d)
         begin
            wdata_q <= wr_data;
            wmask_q <= wr_mask;
            wecc_q <= wr_ecc;
            wecc_mask_q <= wr_ecc_mask;
         end
         rd_valid <= dfi.dfi_rddata_valid;
         if (dfi.dfi_rddata_valid)
         begin
            rd_data <= dfi.dfi_rddata;
            rd_ecc <= dfi.dfi_rdecc;
         end
         // Level controls wait for init and are parked low during an update
         misc_ok_q <= init_ok & (st_q != DFIM_INIT) & (st_q != DFIM_UPD);
      end
   end

   assign dfi.dfi_init_start = init_start_q;
   assign dfi.dfi_ras_n = ras_n_q;
   assign dfi.dfi_cas_n = cas_n_q;
   assign dfi.dfi_we_n = we_n_q;
   assign dfi.dfi_cs_n = cs_n_q;
   assign dfi.dfi_address = addr_q;
   assign dfi.dfi_bank = bank_q;
   assign dfi.dfi_cmd_addr = ca_q;
   assign dfi.dfi_cke = (st_q == DFIM_INIT) ? {CSW{dfi_pkg::CKE_RESET}} : cke_level;
   assign dfi.dfi_odt = misc_ok_q ? odt_level : {CSW{dfi_pkg::ODT_RESET}};
   assign dfi.dfi_wrdata_en = {SLICES{wen_q}};
   assign dfi.dfi_wrecc_en = {SLICES{wen_q}};
   assign dfi.dfi_wrdata = wdata_q;
   assign dfi.dfi_wrdata_mask = wmask_q;
   assign dfi.dfi_wrecc = wecc_q;
   assign dfi.dfi_wrecc_mask = wecc_mask_q;
   assign dfi.dfi_rddata_en = ren_q;
   assign dfi.dfi_rdecc_en = ren_q;
   assign dfi.dfi_dram_clk_disable = misc_ok_q & clk_disable_req;
   assign dfi.dfi_phyupd_ack = upd_ack_q;
   // Low-power offers only while idle; acknowledge is reported, never awaited
   assign dfi.dfi_clp_req = misc_ok_q & idle & lp_cmd_req;
   assign dfi.dfi_clp_wakeup = lp_cmd_wakeup;
   assign dfi.dfi_rdlp_req = misc_ok_q & idle & lp_rd_req;
   assign dfi.dfi_rdlp_wakeup = lp_rd_wakeup;
   assign lp_cmd_acked = dfi.dfi_clp_ack;
   assign lp_rd_acked = dfi.dfi_rdlp_ack;
endmodule
`default_nettype wire

// file: bench/dfi_chk_props.sv
// Concurrent checks on the DFI link between the two ends
`timescale 1ns/1ps
`default_nettype none
module dfi_chk #(
   parameter int SL = 4
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Init and command
   input wire logic dfi_init_complete,
   input wire logic dfi_ras_n,
   input wire logic dfi_cas_n,
   input wire logic dfi_we_n,
   input wire logic [0:0] dfi_cs_n,
   // Data enables
   input wire logic dfi_rddata_en,
   input wire logic dfi_rdecc_en,
   input wire logic [SL-1:0] dfi_wrdata_en,
   input wire logic [SL-1:0] dfi_wrecc_en,
   // Update and low power
   input wire logic dfi_phyupd_req,
   input wire logic dfi_phyupd_ack,
   input wire logic dfi_clp_req
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // Read and write as decoded from the strobes
   sequence s_rd;
      !dfi_cs_n[0] && dfi_ras_n && !dfi_cas_n && dfi_we_n;
   endsequence
   sequence s_wr;
      !dfi_cs_n[0] && dfi_ras_n && !dfi_cas_n && !dfi_we_n;
   endsequence
   AST_INIT_HOLD: assert property (!dfi_init_complete |-> dfi_cs_n[0] && !dfi_phyupd_ack)
      else $error("link active before init");
   AST_RD_LAT: assert property (s_rd |-> ##2 dfi_rddata_en)
      else $error("read enable late");
   AST_RD_ORIGIN: assert property ($rose(dfi_rddata_en) |-> !$past(dfi_cas_n, 2) && $past(dfi_we_n, 2))
      else $error("read enable without read");
   AST_RD_ECC: assert property (dfi_rdecc_en == dfi_rddata_en)
      else $error("read ecc enable differs");
   AST_WR_LAT: assert property (s_wr |-> ##2 dfi_wrdata_en[0])
      else $error("write enable late");
   AST_WR_SLICE: assert property (dfi_wrdata_en == {SL{dfi_wrdata_en[0]}} && dfi_wrecc_en == dfi_wrdata_en)
      else $error("slice enables differ");
   AST_UPD_ACK: assert property ($rose(dfi_phyupd_req) |-> ##[1:60] dfi_phyupd_ack)
      else $error("update not acked");
   AST_UPD_HOLD: assert property (dfi_phyupd_ack && dfi_phyupd_req |=> dfi_phyupd_ack)
      else $error("ack dropped early");
   AST_UPD_QUIET: assert property (dfi_phyupd_ack |-> dfi_cs_n[0] && !dfi_rddata_en && !dfi_wrdata_en[0])
      else $error("traffic during update");
   AST_LP_IDLE: assert property (dfi_clp_req |-> !dfi_phyupd_ack && dfi_init_complete)
      else $error("low power offer while busy");
endmodule
`default_nettype wire

// file: bench/tb_dfi_controller_phy_interface.sv
// Self-checking bench joining the controller and PHY ends
`timescale 1ns/1ps
`default_nettype none
module tb_dfi_controller_phy_interface;
   logic sys_clk = 0, rst_b = 0, cmd_valid = 0, cmd_ras_n = 1, cmd_cas_n = 1, cmd_we_n = 1, freq_req = 0;
   logic clk_disable_req = 0, lp_cmd_req = 0, lp_rd_req = 0, upd_go = 0, lp_ack_en = 0, wp = 0, rp = 0;
   logic cmd_ready, wr_pull, rd_valid, freq_done, init_timeout, lp_cmd_acked, lp_rd_acked, upd_active;
   logic cmd_seen, wr_beat_valid, rd_pop, upd_busy, mem_clk_run;
   logic [1:0] cmd_kind = 0, upd_type = 0;
   logic [3:0] cmd_len = 0, wr_mask = 0, lp_cmd_wakeup = 0, lp_rd_wakeup = 0, wr_beat_mask;
   logic [0:0] cmd_cs_n = 1, cke_level = 1, odt_level = 0, wr_ecc_mask = 0;
   logic [15:0] cmd_addr = 0, cmd_address, aq[$];
   logic [9:0] cmd_ca = 0;
   logic [2:0] cmd_bank = 0, seen_bank;
   logic [31:0] wr_data = 0, rd_src_data = 0, rd_data, wr_beat_data;
   logic [7:0] wr_ecc = 0, rd_src_ecc = 0, rd_ecc, wr_beat_ecc, cfg_wrlat = 2, cfg_wrdata = 2;
   logic [7:0] cfg_rddata_en = 2, cfg_rdlat = 8, cfg_init_cmp = 20;
   logic [43:0] wq[$];
   logic [39:0] rq[$];
   int err_count = 0, comparisons = 0, rcnt = 0, wcnt = 0, rexp = 0, wexp = 0, cyc = 0;
   dfi_if dfi ();
   dfi_mc_end u_dfi_mc_end (.dfi(dfi), .*);
   dfi_phy_end u_dfi_phy_end (.dfi(dfi), .cmd_bank(seen_bank), .*);
   dfi_chk u_dfi_chk (.sys_clk(sys_clk), .rst_b(rst_b), .dfi_init_complete(dfi.dfi_init_complete),
      .dfi_ras_n(dfi.dfi_ras_n), .dfi_cas_n(dfi.dfi_cas_n), .dfi_we_n(dfi.dfi_we_n), .dfi_cs_n(dfi.dfi_cs_n),
      .dfi_rddata_en(dfi.dfi_rddata_en), .dfi_rdecc_en(dfi.dfi_rdecc_en), .dfi_wrdata_en(dfi.dfi_wrdata_en),
      .dfi_wrecc_en(dfi.dfi_wrecc_en), .dfi_phyupd_req(dfi.dfi_phyupd_req), .dfi_phyupd_ack(dfi.dfi_phyupd_ack),
      .dfi_clp_req(dfi.dfi_clp_req));
   always #50 sys_clk = ~sys_clk;
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("comparisons=%0d errors=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Valid is held until ready is seen, so a refused request simply waits
   task automatic cmd(input int k, input int len);
      logic [28:0] r;
      int n;
      r = $urandom;
      aq.push_back(r[28:13]);
      @(posedge sys_clk);
      {cmd_ras_n, cmd_cas_n, cmd_we_n} <= (k == 0) ? 3'h3 : (k == 1) ? 3'h5 : 3'h4;
      {cmd_valid, cmd_cs_n, cmd_kind, cmd_len, cmd_addr, cmd_bank, cmd_ca} <= {2'h2, 2'(k), 4'(len), r};
      @(negedge sys_clk);
      for (n = 0; n < 300 && cmd_ready !== 1; n++) @(negedge sys_clk);
      @(posedge sys_clk) {cmd_valid, cmd_cs_n} <= 2'h1;
      rexp += (k == 1) ? len : 0;
      wexp += (k == 2) ? len : 0;
   endtask
   task automatic freq();
      int n;
      @(posedge sys_clk) freq_req <= 1;
      for (n = 0; n < 50 && dfi.dfi_init_start !== 1; n++) @(negedge sys_clk);
      @(posedge sys_clk) freq_req <= 0;
      for (n = 0; n < 100 && freq_done !== 1; n++) @(negedge sys_clk);
      chk(freq_done, 1);
   endtask
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         err_count++;
         results();
      end
      if (wp) {wr_mask, wr_ecc, wr_data} <= 44'({$urandom, $urandom});
      if (rp) {rd_src_ecc, rd_src_data} <= 40'({$urandom, $urandom});
   end
   // Capture what each end hands over and compare at the far end
   always @(negedge sys_clk)
   begin
      wp <= wr_pull;
      rp <= rd_pop;
      if (wr_pull === 1) wq.push_back({wr_mask, wr_ecc, wr_data});
      if (rd_pop === 1) rq.push_back({rd_src_ecc, rd_src_data});
      if (wr_beat_valid === 1) chk({wr_beat_mask, wr_beat_ecc, wr_beat_data}, wq.pop_front());
      if (rd_valid === 1) chk({rd_ecc, rd_data}, rq.pop_front());
      if (cmd_seen === 1) chk(cmd_address, aq.pop_front());
      wcnt += (wr_beat_valid === 1);
      rcnt += (rd_valid === 1);
   end
   initial
   begin
      int i, n, k;
      void'($urandom(16));
      repeat (5) @(posedge sys_clk);
      rst_b <= 1;
      for (n = 0; n < 50 && cmd_ready !== 1; n++) @(negedge sys_clk);
      chk(cmd_ready, 1);
      for (i = 0; i < 24; i++)
      begin
         if (i % 6 == 0)
         begin
            for (n = 0; n < 100 && upd_busy !== 0; n++) @(negedge sys_clk);
            @(posedge sys_clk) {upd_go, upd_type} <= {1'h1, 2'(i / 6)};
            @(posedge sys_clk) upd_go <= 0;
         end
         k = $urandom % 3;
         cmd(k, (k == 0) ? 0 : (i % 5 == 0) ? 15 : 1 + $urandom % 4);
      end
      repeat (60) @(negedge sys_clk);
      chk(rcnt, rexp);
      chk(wcnt, wexp);
      freq();
      chk(init_timeout, 0);
      @(posedge sys_clk) cfg_init_cmp <= 8'h03;
      freq();
      chk(init_timeout, 1);
      @(posedge sys_clk) {cfg_init_cmp, clk_disable_req} <= {8'h14, 1'h1};
      repeat (4) @(negedge sys_clk);
      chk(mem_clk_run, 0);
      @(posedge sys_clk) clk_disable_req <= 0;
      repeat (4) @(negedge sys_clk);
      chk(mem_clk_run, 1);
      // Second pass leaves the ack off, and a read must still complete
      for (i = 0; i < 2; i++)
      begin
         repeat (20) @(negedge sys_clk);
         @(posedge sys_clk) {lp_ack_en, lp_cmd_req, lp_rd_req, lp_cmd_wakeup, lp_rd_wakeup} <= {1'(1 - i), 2'h3, 8'($urandom)};
         repeat (4) @(negedge sys_clk);
         chk({lp_cmd_acked, lp_rd_acked}, {2{1'(1 - i)}});
         chk({dfi.dfi_clp_req, dfi.dfi_rdlp_req, dfi.dfi_clp_wakeup, dfi.dfi_rdlp_wakeup}, {2'h3, lp_cmd_wakeup, lp_rd_wakeup});
         cmd(1, 3);
         @(posedge sys_clk) {lp_cmd_req, lp_rd_req} <= 2'h0;
      end
      repeat (40) @(negedge sys_clk);
      chk(rcnt, rexp);
      results();
   end
endmodule
`default_nettype wire
